// file: hdl/monitor_config_status_regs.v
// configuration register one and limit fault status register one of the monitor
// How it works
// - start bit set: programmed limits drive fans
// - start bit clear: default limits, monitoring stops
// - clearing start keeps stored programmed limits
// - start bit writable even after freeze
// - freeze bit write-once; locks lockable registers
// - ready flag set once powered up
// - full speed force: max duty, never locked
// - spin-up pulse disable holds drive whole timeout
// - timeout enable releases bus after 35 ms
// - status bit 0 on 2.5 V window fault
// - overtemp pin mode: bit 0 from timer
// - bits 1-3: core, supply, 5 V faults
// - bits 4 and 6: remote temperature faults
// - bit 5: local temperature fault
// - read clears only flags whose fault subsided
// - bit 7 is OR of status two
// - status one resets to zero
// - configuration one reads 0x00 after reset, 0x04 once ready
// - monitoring off drives fans at full duty
`timescale 1ns/1ps
`default_nettype none
`include "monitor_config_status_map.vh"

module monitor_config_status_regs #(
  parameter integer TIMEOUT_CYCLES = `BUS_TIMEOUT_CYCLES,
  parameter integer READY_CYCLES = `READY_DELAY_CYCLES
) (
  input wire clk,
  input wire reset,
  // register port from the serial bus engine
  input wire [7:0] regAddr,
  input wire [7:0] regWrData,
  input wire regWrite,
  input wire regRead,
  output reg [7:0] regRdData,
  // serial bus state for the stall timeout
  input wire inTransaction,
  input wire busActivity,
  output wire busRelease,
  // limit comparator results, level, high while out of window
  input wire faultVin25,
  input wire faultCoreVolt,
  input wire faultSupply,
  input wire faultVin5,
  input wire faultRemote1,
  input wire faultLocal,
  input wire faultRemote2,
  // pin 22 used as overtemperature signal, and its timer over limit
  input wire overtempPinMode,
  input wire overtempTimerOver,
  // second status register contents
  input wire [7:0] statusTwo,
  // power-up done from the analog front end
  input wire powerGood,
  // fan control steering
  output wire monitorEnable,
  output wire useProgrammedLimits,
  output wire forceFullDuty,
  output wire forceMaxProgrammed,
  output wire spinupPulseDisable,
  output wire cpuPowerReport,
  output wire settingsLocked
);

  localparam integer RDY_W = 8;
  localparam integer TMO_W = 26;
  localparam [7:0] CFG_RESET = `CFG_ONE_RESET;

  // power-up sequencer, one-hot
  localparam [2:0] PWR_WAIT = 3'b001;
  localparam [2:0] PWR_SETTLE = 3'b010;
  localparam [2:0] PWR_READY = 3'b100;

  reg [2:0] pwrState_q;
  reg [2:0] pwrState_d;
  reg [RDY_W-1:0] readyCnt_q;
  reg [RDY_W-1:0] readyCnt_d;
  reg ready_q;
  reg startBit_q;
  reg freezeBit_q;
  reg fullSpeedBit_q;
  reg cpuPowerBit_q;
  reg spinupDisBit_q;
  reg timeoutEnBit_q;
  reg [7:0] status_q;
  reg [7:0] status_d;
  reg [7:0] rdMux;
  wire [7:0] cfgBits;
  wire [6:0] faultNow;
  wire cfgWrite;
  wire statusRead;
  wire summaryNow;
  integer i;

  // address compare shared by the write and read decode
  function addrHit;
    input [7:0] addr;
    input [7:0] target;
    begin
      addrHit = (addr == target);
    end
  endfunction

  // lockable field: new data only while settings are not frozen
  function lockField;
    input current;
    input wrBit;
    input frozen;
    begin
      if (frozen)
        lockField = current;
      else
        lockField = wrBit;
    end
  endfunction

  // one limit flag; a fault still present in the read cycle keeps it set
  function flagNext;
    input flag;
    input fault;
    input readNow;
    input running;
    begin
      flagNext = flag;
      if (readNow)
        flagNext = flag & fault;
      if (running)
        flagNext = flagNext | fault;
    end
  endfunction

  // status bit 0 source depends on pin 22 function
  assign faultNow = {faultRemote2, faultLocal, faultRemote1, faultVin5, faultSupply,
    faultCoreVolt, overtempPinMode ? overtempTimerOver : faultVin25};

  assign cfgWrite = regWrite && addrHit(regAddr, `CFG_ONE_ADDR);
  assign statusRead = regRead && addrHit(regAddr, `STATUS_ONE_ADDR);
  assign summaryNow = |statusTwo;

  // ready flag after a short settle once power is good; sticky until reset
  always @*
  begin
    pwrState_d = pwrState_q;
    readyCnt_d = readyCnt_q;
    case (pwrState_q)
      PWR_WAIT:
      begin
        readyCnt_d = {RDY_W{1'b0}};
        if (powerGood)
          pwrState_d = PWR_SETTLE;
      end
      PWR_SETTLE:
      begin
        if (readyCnt_q >= READY_CYCLES[RDY_W-1:0])
          pwrState_d = PWR_READY;
        else
          readyCnt_d = readyCnt_q + {{(RDY_W-1){1'b0}}, 1'b1};
      end
      PWR_READY:
      begin
        pwrState_d = PWR_READY;
      end
      default:
      begin
        pwrState_d = PWR_WAIT;
      end
    endcase
  end

  always @(posedge clk)
  begin
    if (reset)
    begin
      pwrState_q <= PWR_WAIT;
      readyCnt_q <= {RDY_W{1'b0}};
      ready_q <= 1'b0;
    end
    else
    begin
      pwrState_q <= pwrState_d;
      readyCnt_q <= readyCnt_d;
      ready_q <= (pwrState_d == PWR_READY);
    end
  end

  // start bit ignores the freeze; the limits it selects live elsewhere
  always @(posedge clk)
  begin
    if (reset)
      startBit_q <= CFG_RESET[`CFG_START_BIT];
    else if (cfgWrite)
    begin
      startBit_q <= regWrData[`CFG_START_BIT];
    end
  end

  // write-once: only reset (power cycle) clears it
  always @(posedge clk)
  begin
    if (reset)
      freezeBit_q <= CFG_RESET[`CFG_FREEZE_BIT];
    else if (cfgWrite)
    begin
      freezeBit_q <= lockField(freezeBit_q, regWrData[`CFG_FREEZE_BIT], freezeBit_q);
    end
  end

  always @(posedge clk)
  begin
    if (reset)
      fullSpeedBit_q <= CFG_RESET[`CFG_FULL_SPEED_BIT];
    else if (cfgWrite)
    begin
      fullSpeedBit_q <= regWrData[`CFG_FULL_SPEED_BIT];
    end
  end

  always @(posedge clk)
  begin
    if (reset)
      cpuPowerBit_q <= CFG_RESET[`CFG_CPU_POWER_BIT];
    else if (cfgWrite)
    begin
      cpuPowerBit_q <= lockField(cpuPowerBit_q, regWrData[`CFG_CPU_POWER_BIT], freezeBit_q);
    end
  end

  always @(posedge clk)
  begin
    if (reset)
      spinupDisBit_q <= CFG_RESET[`CFG_SPINUP_DIS_BIT];
    else if (cfgWrite)
    begin
      spinupDisBit_q <= lockField(spinupDisBit_q, regWrData[`CFG_SPINUP_DIS_BIT], freezeBit_q);
    end
  end

  always @(posedge clk)
  begin
    if (reset)
      timeoutEnBit_q <= CFG_RESET[`CFG_TIMEOUT_EN_BIT];
    else if (cfgWrite)
    begin
      timeoutEnBit_q <= lockField(timeoutEnBit_q, regWrData[`CFG_TIMEOUT_EN_BIT], freezeBit_q);
    end
  end

  // bit 2 shows the live ready flag, reserved bit 7 reads zero
  assign cfgBits = {1'b0, timeoutEnBit_q, spinupDisBit_q, cpuPowerBit_q, fullSpeedBit_q,
    ready_q, freezeBit_q, startBit_q};

  // status latch: set wins over read clear, read clears only subsided faults
  always @*
  begin
    status_d = status_q;
    for (i = 0; i < 7; i = i + 1)
    begin
      status_d[i] = flagNext(status_q[i], faultNow[i], statusRead, startBit_q);
    end
    status_d[`ST_SUMMARY_BIT] = summaryNow;
  end

  always @(posedge clk)
  begin
    if (reset)
      status_q <= `STATUS_ONE_RESET;
    else
      status_q <= status_d;
  end

  // read shows the flags as they stood before this read's clear
  always @*
  begin
    rdMux = 8'h00;
    case (regAddr)
      `CFG_ONE_ADDR:
      begin
        rdMux = cfgBits;
      end
      `STATUS_ONE_ADDR:
      begin
        rdMux = {summaryNow, status_q[6:0]};
      end
      default:
      begin
        rdMux = 8'h00;
      end
    endcase
  end

  always @(posedge clk)
  begin
    if (reset)
      regRdData <= 8'h00;
    else if (regRead)
      regRdData <= rdMux;
  end

  assign monitorEnable = startBit_q;
  assign useProgrammedLimits = startBit_q;
  // thermal protection when monitoring stopped
  assign forceFullDuty = !startBit_q;
  assign forceMaxProgrammed = fullSpeedBit_q;
  assign spinupPulseDisable = spinupDisBit_q;
  assign cpuPowerReport = cpuPowerBit_q;
  assign settingsLocked = freezeBit_q;

  // stall watchdog; the serial engine lets go of the bus on expiry
  bus_idle_timer #(
    .LIMIT(TIMEOUT_CYCLES),
    .WIDTH(TMO_W)
  ) bus_idle_timer_inst (
    .clk(clk),
    .reset(reset),
    .enable(timeoutEnBit_q),
    .inTransaction(inTransaction),
    .busActivity(busActivity),
    .expired(busRelease)
  );

endmodule // monitor_config_status_regs

`default_nettype wire

// file: pkg/monitor_config_status_map.vh
// register offsets, field positions, reset values and timing counts of the monitor register bank
`ifndef MONITOR_CONFIG_STATUS_MAP_VH
`define MONITOR_CONFIG_STATUS_MAP_VH

`define CFG_ONE_ADDR 8'h40
`define STATUS_ONE_ADDR 8'h41
`define STATUS_TWO_ADDR 8'h42

`define CFG_ONE_RESET 8'h04
`define STATUS_ONE_RESET 8'h00

`define CFG_START_BIT 0
`define CFG_FREEZE_BIT 1
`define CFG_READY_BIT 2
`define CFG_FULL_SPEED_BIT 3
`define CFG_CPU_POWER_BIT 4
`define CFG_SPINUP_DIS_BIT 5
`define CFG_TIMEOUT_EN_BIT 6

`define ST_SUMMARY_BIT 7

`define FULL_DUTY 8'hFF

`define BUS_TIMEOUT_MS 35
`define CLK_FREQ_KHZ 100000
`define BUS_TIMEOUT_CYCLES (`BUS_TIMEOUT_MS * `CLK_FREQ_KHZ)
`define READY_DELAY_CYCLES 16

`endif

// file: hdl/bus_idle_timer.v
// counts cycles of bus inactivity and flags a stalled transaction
`timescale 1ns/1ps
`default_nettype none

module bus_idle_timer #(
  parameter integer LIMIT = 3500000,
  parameter integer WIDTH = 22
) (
  input wire clk,
  input wire reset,
  input wire enable,
  input wire inTransaction,
  input wire busActivity,
  output reg expired
);

  reg [WIDTH-1:0] count_q;

  always @(posedge clk)
  begin
    if (reset || !enable || !inTransaction || busActivity)
    begin
      count_q <= {WIDTH{1'b0}};
      expired <= 1'b0;
    end
    else if (count_q < LIMIT[WIDTH-1:0])
    begin
      count_q <= count_q + {{(WIDTH-1){1'b0}}, 1'b1};
      expired <= 1'b0;
    end
    else
    begin
      // strictly more than the limit of silence
      expired <= 1'b1;
    end
  end

endmodule // bus_idle_timer

`default_nettype wire

// file: bench/monitor_config_status_sva.sv
// port assertions of the monitor register bank
`timescale 1ns/1ps
`default_nettype none
module monitor_config_status_sva (
  input wire clk,
  input wire reset,
  input wire [7:0] regAddr,
  input wire [7:0] regWrData,
  input wire regWrite,
  input wire regRead,
  input wire [7:0] regRdData,
  input wire [7:0] statusTwo,
  input wire inTransaction,
  input wire busRelease,
  input wire monitorEnable,
  input wire useProgrammedLimits,
  input wire forceFullDuty,
  input wire forceMaxProgrammed,
  input wire spinupPulseDisable,
  input wire cpuPowerReport,
  input wire settingsLocked
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  sequence s_cfgWr;
    regWrite && regAddr == 8'h40;
  endsequence
  property p_steer; useProgrammedLimits == monitorEnable; endproperty
  a_steer: assert property (p_steer) else $error("limit steering wrong");
  property p_full; forceFullDuty == !monitorEnable; endproperty
  a_full: assert property (p_full) else $error("full duty wrong");
  property p_start; s_cfgWr |=> monitorEnable == $past(regWrData[0]); endproperty
  a_start: assert property (p_start) else $error("start bit not written");
  property p_fast; s_cfgWr |=> forceMaxProgrammed == $past(regWrData[3]); endproperty
  a_fast: assert property (p_fast) else $error("full speed not written");
  property p_freeze; settingsLocked |=> settingsLocked; endproperty
  a_freeze: assert property (p_freeze) else $error("freeze dropped");
  property p_lock;
    s_cfgWr ##0 settingsLocked |=> $stable(cpuPowerReport) && $stable(spinupPulseDisable);
  endproperty
  a_lock: assert property (p_lock) else $error("locked bit changed");
  property p_spin;
    s_cfgWr ##0 !settingsLocked |=> spinupPulseDisable == $past(regWrData[5]);
  endproperty
  a_spin: assert property (p_spin) else $error("spin-up bit not written");
  property p_sum; regRead && regAddr == 8'h41 |=> regRdData[7] == $past(|statusTwo); endproperty
  a_sum: assert property (p_sum) else $error("summary bit wrong");
  property p_init; $fell(reset) |-> regRdData == 8'h00 && !busRelease; endproperty
  a_init: assert property (p_init) else $error("reset outputs wrong");
  property p_rel; busRelease |-> $past(inTransaction); endproperty
  a_rel: assert property (p_rel) else $error("release outside transaction");
endmodule // monitor_config_status_sva
bind monitor_config_status_regs monitor_config_status_sva monitor_config_status_sva_inst (.*);
`default_nettype wire

// file: bench/bus_stall_host.sv
// host side that stalls a transaction to provoke the bus timeout
`timescale 1ns/1ps
`default_nettype none
module bus_stall_host (
  input wire logic clk,
  input wire logic stall,
  output logic inTransaction = 1'h0,
  output logic busActivity = 1'h0
);
  // idle activity toggles so a stuck level never reads as silence
  always @(negedge clk)
  begin
    inTransaction <= stall;
    busActivity <= !stall && !busActivity;
  end
endmodule // bus_stall_host
`default_nettype wire

// file: bench/tb_monitor_config_status_regs.sv
// self-checking bench of the monitor register bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) \
  begin \
    compares++; \
    if ((a) !== (b)) \
      $display("CHECK FAILED at %0t: %h vs %h", $time, a, b); \
    if ((a) !== (b)) \
      err_count++; \
  end
module tb_monitor_config_status_regs;
  logic clk = 1'h0, reset = 1'h1, regWrite = 1'h0, regRead = 1'h0, powerGood = 1'h0;
  logic stall = 1'h0, overtempPinMode = 1'h0, overtempTimerOver = 1'h0;
  logic [7:0] regAddr = '0, regWrData = '0, statusTwo = '0;
  logic [6:0] flt = '0;
  wire [7:0] regRdData;
  wire inTransaction, busActivity, busRelease, monitorEnable, useProgrammedLimits;
  wire forceFullDuty, forceMaxProgrammed, spinupPulseDisable, cpuPowerReport, settingsLocked;
  wire faultVin25, faultCoreVolt, faultSupply, faultVin5, faultRemote1, faultLocal, faultRemote2;
  int err_count = 0, compares = 0, cyc = 0;
  assign {faultRemote2, faultLocal, faultRemote1, faultVin5, faultSupply, faultCoreVolt,
    faultVin25} = flt;
  monitor_config_status_regs #(.TIMEOUT_CYCLES(20)) monitor_config_status_regs_inst (.*);
  bus_stall_host bus_stall_host_inst (.*);
  initial
  begin
    forever #5 clk = !clk;
  end
  task close_out;
    $display("mismatches %0d of %0d compares", err_count, compares);
    if (err_count == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task wr(input [7:0] a, input [7:0] d);
    @(negedge clk);
    regAddr = a;
    regWrData = d & 8'h7F;
    regWrite = 1'h1;
    @(negedge clk);
    regWrite = 1'h0;
  endtask
  task rd(input [7:0] a, input [7:0] e);
    @(negedge clk);
    regAddr = a;
    regRead = 1'h1;
    @(negedge clk);
    regRead = 1'h0;
    `CHK(regRdData, e)
  endtask
  task t_power;
    rd(8'h40, 8'h00);
    rd(8'h41, 8'h00);
    powerGood = 1'h1;
    repeat (20) @(negedge clk);
    rd(8'h40, 8'h04);
  endtask
  task t_flags;
    flt = 7'h7F;
    rd(8'h41, 8'h00);
    wr(8'h40, 8'h01);
    statusTwo = 8'h10;
    rd(8'h41, 8'hFF);
    flt = 7'h20;
    statusTwo = 8'h00;
    rd(8'h41, 8'h7F);
    rd(8'h41, 8'h20);
    flt = 7'h00;
    overtempPinMode = 1'h1;
    overtempTimerOver = 1'h1;
    rd(8'h41, 8'h21);
    overtempTimerOver = 1'h0;
    rd(8'h41, 8'h01);
    rd(8'h41, 8'h00);
    rd(8'h55, 8'h00);
  endtask
  task t_lock;
    wr(8'h40, 8'hFB);
    rd(8'h40, 8'h7F);
    `CHK(monitorEnable, 1'h1)
    `CHK(useProgrammedLimits, 1'h1)
    `CHK(forceMaxProgrammed, 1'h1)
    `CHK(spinupPulseDisable, 1'h1)
    `CHK(cpuPowerReport, 1'h1)
    wr(8'h40, 8'h00);
    rd(8'h40, 8'h76);
    `CHK(forceFullDuty, 1'h1)
    `CHK(useProgrammedLimits, 1'h0)
    `CHK(forceMaxProgrammed, 1'h0)
    `CHK(spinupPulseDisable, 1'h1)
    `CHK(cpuPowerReport, 1'h1)
    stall = 1'h1;
    repeat (19) @(negedge clk);
    `CHK(busRelease, 1'h0)
    repeat (8) @(negedge clk);
    `CHK(busRelease, 1'h1)
    stall = 1'h0;
    reset = 1'h1;
    @(negedge clk);
    reset = 1'h0;
    @(negedge clk);
    `CHK(settingsLocked, 1'h0)
  endtask
  // hang guard well above the hundred or so cycles the sequence needs
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 2000)
    begin
      err_count++;
      close_out;
    end
  end
  initial
  begin
    repeat (10) @(negedge clk);
    reset = 1'h0;
    t_power;
    t_flags;
    t_lock;
    close_out;
  end
endmodule // tb_monitor_config_status_regs
`default_nettype wire
